// ===== design/bmsq_regs.vh
`ifndef BMSQ_REGS_VH
`define BMSQ_REGS_VH
// fixed shared-memory words
`define BMSQ_SP_A 16'h0100
`define BMSQ_MC_A 16'h0101
`define BMSQ_SP_B 16'h0104
`define BMSQ_MC_B 16'h0105
`define BMSQ_LUT_A 16'h0140
`define BMSQ_LUT_B 16'h01C0
// descriptor entry word offsets
`define BMSQ_DE_STATUS 16'h0000
`define BMSQ_DE_TAG 16'h0001
`define BMSQ_DE_PTR 16'h0003
`define BMSQ_DE_STEP 8'h04
// block status word fields
`define BMSQ_BS_BEGIN 0
`define BMSQ_BS_DONE 1
`define BMSQ_BS_ERR 2
// control word fields
`define BMSQ_CW_BCST 1
// mode encodings of cfg_mode
`define BMSQ_MODE_BC 2'h0
`define BMSQ_MODE_RT 2'h1
// host register port offsets
`define BMSQ_REG_CFG 4'h0
`define BMSQ_REG_MASK 4'h1
`define BMSQ_REG_START 4'h2
`define BMSQ_REG_STAT 4'h3
`define BMSQ_REG_COUNT 4'h4
// config fields
`define BMSQ_CFG_MODE_LO 0
`define BMSQ_CFG_AREA 2
`define BMSQ_CFG_HALT 3
// mask fields
`define BMSQ_MSK_ERR 0
`define BMSQ_MSK_DONE 1
`define BMSQ_MSK_FRAME 2
// reset values, all-ones word
`define BMSQ_CFG_RST 4'h0
`define BMSQ_MSK_RST 3'h0
`define BMSQ_ALL_ONES 16'hFFFF
`endif

// ===== design/bmsq_seq.v
`timescale 1ns/1ps
// Notes on behaviour
// - reset or config write selects controller mode
// - controller uses pointer/count words 0100-0105
// - control word bit 1 selects broadcast
// - halt on error after current message unless count reaches all ones
// - low interrupt pulse per enabled event
// - start: pointer, begin flag, tag, block address
// - end: irq, reread pointer, status, tag
// - pointer plus four, count plus one
// - frame irq when enabled, messages remain
// - config write selects terminal mode
// - terminal uses pointers and lookup tables
// - lookup indexed by t/r and subaddress
// - receive entries 0-31, transmit 32-63
// - pointer low byte wraps, high fixed
// - mode commands with data map normally
// - frame done when count reaches all ones
// - time tag written from external source
`include "bmsq_regs.vh"
module bmsq_seq (
  input wire clock,
  input wire sys_rst,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  output reg [15:0] mem_addr,
  output reg [15:0] mem_wdata,
  output reg mem_wr,
  output reg mem_rd,
  input wire [15:0] mem_rdata,
  output reg tag_en_n,
  output reg [15:0] xfer_block_ptr,
  output reg xfer_start,
  output reg xfer_broadcast,
  input wire xfer_done,
  input wire xfer_error,
  input wire [15:0] rt_cmd,
  input wire rt_cmd_valid,
  output wire int_n
);
  // ************************************************
  // state encodings
  // ************************************************
  localparam S_IDLE = 4'h0;
  localparam S_SP = 4'h1;
  localparam S_BEGIN = 4'h2;
  localparam S_TAG1 = 4'h3;
  localparam S_PTR = 4'h4;
  localparam S_CW = 4'h5;
  localparam S_XFER = 4'h6;
  localparam S_SP2 = 4'h7;
  localparam S_DONE = 4'h8;
  localparam S_TAG2 = 4'h9;
  localparam S_WSP = 4'hA;
  localparam S_MC = 4'hB;
  localparam S_WMC = 4'hC;
  localparam S_LUT = 4'hD;
  // ************************************************
  // registers
  // ************************************************
  reg [3:0] cfg_reg;
  reg [2:0] mask_reg;
  reg [3:0] state_reg;
  reg [15:0] sp_reg;
  reg [15:0] mc_reg;
  reg [15:0] msgs_reg;
  reg err_reg;
  reg halted_reg;
  reg rt_reg;
  reg [15:0] cmd_reg;
  reg irq_reg;
  reg [15:0] blk_reg;
  // pointer step: high byte fixed, low byte wraps
  function [15:0] ptr_add;
    input [15:0] p;
    input [7:0] n;
    begin
      ptr_add = {p[15:8], p[7:0] + n};
    end
  endfunction
  wire area_b = cfg_reg[`BMSQ_CFG_AREA];
  wire rt_mode = (cfg_reg[1:0] == `BMSQ_MODE_RT);
  wire [15:0] sp_addr = area_b ? `BMSQ_SP_B : `BMSQ_SP_A;
  wire [15:0] mc_addr = area_b ? `BMSQ_MC_B : `BMSQ_MC_A;
  wire [15:0] lut_base = area_b ? `BMSQ_LUT_B : `BMSQ_LUT_A;
  // t/r bit is top index bit, subaddress low five
  wire [5:0] lut_idx = {cmd_reg[10], cmd_reg[9:5]};
  wire [15:0] mc_inc = mc_reg + 16'h0001;
  assign int_n = ~irq_reg;
  // ************************************************
  // host register port
  // ************************************************
  always @(posedge clock) begin
    if (sys_rst) begin
      cfg_reg <= `BMSQ_CFG_RST;
      mask_reg <= `BMSQ_MSK_RST;
      reg_rdata <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == `BMSQ_REG_CFG)
        cfg_reg <= reg_wdata[3:0];
      if (reg_wr && reg_addr == `BMSQ_REG_MASK)
        mask_reg <= reg_wdata[2:0];
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        case (reg_addr)
          `BMSQ_REG_CFG: reg_rdata <= {12'h000, cfg_reg};
          `BMSQ_REG_MASK: reg_rdata <= {13'h0000, mask_reg};
          `BMSQ_REG_STAT: reg_rdata <= {8'h00, state_reg, 1'b0, err_reg, halted_reg, rt_mode};
          `BMSQ_REG_COUNT: reg_rdata <= msgs_reg;
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end
  // ************************************************
  // sequencer
  // ************************************************
  always @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= S_IDLE;
      sp_reg <= 16'h0000;
      mc_reg <= 16'h0000;
      msgs_reg <= 16'h0000;
      err_reg <= 1'b0;
      halted_reg <= 1'b0;
      rt_reg <= 1'b0;
      cmd_reg <= 16'h0000;
      irq_reg <= 1'b0;
      blk_reg <= 16'h0000;
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      tag_en_n <= 1'b1;
      xfer_block_ptr <= 16'h0000;
      xfer_start <= 1'b0;
      xfer_broadcast <= 1'b0;
    end else begin
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      tag_en_n <= 1'b1;
      xfer_start <= 1'b0;
      irq_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (!rt_mode && !halted_reg && reg_wr && reg_addr == `BMSQ_REG_START) begin
            rt_reg <= 1'b0;
            mem_addr <= sp_addr;
            mem_rd <= 1'b1;
            state_reg <= S_SP;
          end else if (rt_mode && rt_cmd_valid) begin
            rt_reg <= 1'b1;
            cmd_reg <= rt_cmd;
            mem_addr <= sp_addr;
            mem_rd <= 1'b1;
            state_reg <= S_SP;
          end
          if (reg_wr && reg_addr == `BMSQ_REG_START && reg_wdata[1])
            halted_reg <= 1'b0;
        end
        S_SP: begin
          // read data is valid in the cycle the strobe is high
          sp_reg <= mem_rdata;
          mem_addr <= mem_rdata + `BMSQ_DE_STATUS;
          mem_wdata <= 16'h0001 << `BMSQ_BS_BEGIN;
          mem_wr <= 1'b1;
          state_reg <= S_BEGIN;
        end
        S_BEGIN: begin
          mem_addr <= sp_reg + `BMSQ_DE_TAG;
          mem_wr <= 1'b1;
          tag_en_n <= 1'b0;
          mem_wdata <= `BMSQ_ALL_ONES;
          state_reg <= S_TAG1;
        end
        S_TAG1: begin
          mem_rd <= 1'b1;
          if (rt_reg) begin
            mem_addr <= lut_base + {10'h000, lut_idx};
            state_reg <= S_LUT;
          end else begin
            mem_addr <= sp_reg + `BMSQ_DE_PTR;
            state_reg <= S_PTR;
          end
        end
        S_PTR: begin
          blk_reg <= mem_rdata;
          mem_addr <= mem_rdata;
          mem_rd <= 1'b1;
          state_reg <= S_CW;
        end
        S_CW: begin
          xfer_block_ptr <= ptr_add(blk_reg, 8'h01);
          xfer_broadcast <= mem_rdata[`BMSQ_CW_BCST];
          xfer_start <= 1'b1;
          state_reg <= S_XFER;
        end
        S_LUT: begin
          xfer_block_ptr <= mem_rdata;
          xfer_broadcast <= 1'b0;
          xfer_start <= 1'b1;
          state_reg <= S_XFER;
        end
        S_XFER: begin
          if (xfer_done) begin
            err_reg <= xfer_error;
            irq_reg <= xfer_error ? mask_reg[`BMSQ_MSK_ERR] : mask_reg[`BMSQ_MSK_DONE];
            mem_addr <= sp_addr;
            mem_rd <= 1'b1;
            state_reg <= S_SP2;
          end
        end
        S_SP2: begin
          sp_reg <= mem_rdata;
          mem_addr <= mem_rdata + `BMSQ_DE_STATUS;
          mem_wdata <= (16'h0001 << `BMSQ_BS_DONE) | ({15'h0000, err_reg} << `BMSQ_BS_ERR);
          mem_wr <= 1'b1;
          state_reg <= S_DONE;
        end
        S_DONE: begin
          mem_addr <= sp_reg + `BMSQ_DE_TAG;
          mem_wr <= 1'b1;
          tag_en_n <= 1'b0;
          mem_wdata <= `BMSQ_ALL_ONES;
          state_reg <= S_TAG2;
        end
        S_TAG2: begin
          mem_addr <= sp_addr;
          mem_wdata <= ptr_add(sp_reg, `BMSQ_DE_STEP);
          mem_wr <= 1'b1;
          msgs_reg <= msgs_reg + 16'h0001;
          state_reg <= S_WSP;
        end
        S_WSP: begin
          if (rt_reg) begin
            state_reg <= S_IDLE;
          end else begin
            mem_addr <= mc_addr;
            mem_rd <= 1'b1;
            state_reg <= S_MC;
          end
        end
        S_MC: begin
          mc_reg <= mem_rdata;
          state_reg <= S_WMC;
        end
        S_WMC: begin
          mem_addr <= mc_addr;
          mem_wdata <= mc_inc;
          mem_wr <= 1'b1;
          if (mc_inc == `BMSQ_ALL_ONES) begin
            irq_reg <= mask_reg[`BMSQ_MSK_FRAME];
            state_reg <= S_IDLE;
          end else if (err_reg && cfg_reg[`BMSQ_CFG_HALT]) begin
            halted_reg <= 1'b1;
            state_reg <= S_IDLE;
          end else begin
            // more messages remain: frame irq, wait for next start
            irq_reg <= mask_reg[`BMSQ_MSK_FRAME];
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule // bmsq_seq

// ===== testbench/bmsq_seq_sva.sv
`timescale 1ns/1ps
// ***
// sequencer checker
// ***
module bmsq_seq_sva (
  input logic clock,
  input logic sys_rst,
  input logic [15:0] mem_addr,
  input logic [15:0] mem_wdata,
  input logic mem_wr,
  input logic mem_rd,
  input logic [15:0] mem_rdata,
  input logic tag_en_n,
  input logic xfer_start,
  input logic xfer_done,
  input logic int_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [15:0] sp_v;
  logic [15:0] mc_v;
  // last pointer and count words, taken in the read cycle
  always @(posedge clock) begin
    if (mem_rd && mem_addr[15:3] == 13'h0020 && mem_addr[0]) mc_v <= mem_rdata;
    if (mem_rd && mem_addr[15:3] == 13'h0020 && !mem_addr[0]) sp_v <= mem_rdata;
  end
  property p_tag_wr; !tag_en_n |-> mem_wr && mem_wdata == 16'hFFFF; endproperty
  a_tag_wr: assert property (p_tag_wr) else $error("tag write bad");
  property p_tag_pulse; !tag_en_n |=> tag_en_n; endproperty
  a_tag_pulse: assert property (p_tag_pulse) else $error("tag enable long");
  property p_int_pulse; $fell(int_n) |=> $rose(int_n); endproperty
  a_int_pulse: assert property (p_int_pulse) else $error("irq pulse long");
  property p_start_rd; xfer_start |-> $past(mem_rd); endproperty
  a_start_rd: assert property (p_start_rd) else $error("start without read");
  property p_done_rd; xfer_done |-> ##[1:4] (mem_rd && mem_addr[15:3] == 13'h0020); endproperty
  a_done_rd: assert property (p_done_rd) else $error("no pointer reread");
  property p_done_tag; xfer_done |-> ##[2:8] !tag_en_n; endproperty
  a_done_tag: assert property (p_done_tag) else $error("no end tag");
  property p_sp_step;
    mem_wr && mem_addr[15:3] == 13'h0020 && !mem_addr[0] && tag_en_n
      |-> mem_wdata == {sp_v[15:8], sp_v[7:0] + 8'h04};
  endproperty
  a_sp_step: assert property (p_sp_step) else $error("pointer step bad");
  property p_mc_step; mem_wr && mem_addr[15:3] == 13'h0020 && mem_addr[0] |-> mem_wdata == mc_v + 16'h0001; endproperty
  a_mc_step: assert property (p_mc_step) else $error("count step bad");
  c_start: cover property (xfer_start);
  c_irq: cover property ($fell(int_n));
  c_done: cover property (xfer_done);
endmodule // bmsq_seq_sva

// ===== testbench/bmsq_far.sv
`timescale 1ns/1ps
// ***
// shared ram and bus engine
// ***
module bmsq_far (
  input logic clock,
  input logic [15:0] mem_addr,
  input logic [15:0] mem_wdata,
  input logic mem_wr,
  input logic mem_rd,
  output logic [15:0] mem_rdata,
  input logic xfer_start,
  output logic xfer_done = 1'b0,
  output logic xfer_error = 1'b0,
  input logic err_req,
  input logic slow
);
  logic [15:0] ram [0:8191];
  int cnt = 0;
  // read data stand while the strobe is high, inverse otherwise
  assign mem_rdata = mem_rd ? ram[mem_addr[12:0]] : ~ram[mem_addr[12:0]];
  // ram write and bus engine
  always @(posedge clock) begin
    if (mem_wr) ram[mem_addr[12:0]] <= mem_wdata;
    xfer_done <= 1'b0;
    xfer_error <= 1'b0;
    if (xfer_start) cnt <= slow ? 20 : 2;
    else if (cnt > 0) begin
      cnt <= cnt - 1;
      xfer_done <= cnt == 1;
      xfer_error <= cnt == 1 && err_req;
    end
  end
endmodule // bmsq_far

// ===== testbench/tb_bus1553_bc_rtu_msg_sequencer.sv
`timescale 1ns/1ps
// ***
// sequencer bench
// ***
module tb_bus1553_bc_rtu_msg_sequencer;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rt_cmd_valid = 1'b0;
  logic err_req = 1'b0;
  logic slow = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] rt_cmd = 16'h0000;
  logic [15:0] reg_rdata, mem_addr, mem_wdata, mem_rdata, xfer_block_ptr, bp, d;
  logic mem_wr, mem_rd, tag_en_n, xfer_start, xfer_broadcast, xfer_done, xfer_error, int_n, bc;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int irqs = 0;
  int starts = 0;
  initial forever #4 clock = ~clock;
  bmsq_seq i_dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .tag_en_n(tag_en_n),
    .xfer_block_ptr(xfer_block_ptr), .xfer_start(xfer_start), .xfer_broadcast(xfer_broadcast),
    .xfer_done(xfer_done), .xfer_error(xfer_error), .rt_cmd(rt_cmd), .rt_cmd_valid(rt_cmd_valid), .int_n(int_n));
  bmsq_far i_far (.clock(clock), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata), .xfer_start(xfer_start), .xfer_done(xfer_done), .xfer_error(xfer_error),
    .err_req(err_req), .slow(slow));
  // watch starts and irqs, cut hangs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (int_n === 1'b0) irqs <= irqs + 1;
    if (xfer_start === 1'b1) begin
      starts <= starts + 1;
      bp <= xfer_block_ptr;
      bc <= xfer_broadcast;
    end
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  task summarize;
    if (err_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task m(input logic [15:0] a, input logic [15:0] v);
    i_far.ram[a[12:0]] = v;
  endtask
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task rt(input logic tr, input logic [4:0] sa);
    @(posedge clock);
    rt_cmd <= {5'h00, tr, sa, 5'h00};
    rt_cmd_valid <= 1'b1;
    @(posedge clock);
    rt_cmd_valid <= 1'b0;
  endtask
  // wait for a write to one word
  task ww(input logic [15:0] a);
    for (int i = 0; i < 300 && !(mem_wr === 1'b1 && mem_addr === a); i++) @(negedge clock);
    repeat (3) @(posedge clock);
  endtask
  initial begin
    logic [5:0] k;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    // one broadcast message, pointer wrap, frame irq
    m(16'h0100, 16'h10FC);
    m(16'h0101, 16'hFFFE);
    m(16'h10FF, 16'h0200);
    m(16'h0200, 16'h0002);
    slow <= 1'b1;
    wr(4'h1, 16'h0004);
    wr(4'h2, 16'h0001);
    ww(16'h0101);
    chk("block", 16'h0201, bp);
    chk("bcast", 16'h0001, {15'h0000, bc});
    chk("status", 16'h0002, i_far.ram[13'h10FC]);
    chk("tag", 16'hFFFF, i_far.ram[13'h10FD]);
    chk("sp", 16'h1000, i_far.ram[13'h0100]);
    chk("count", 16'hFFFF, i_far.ram[13'h0101]);
    chk("irq", 16'h0001, irqs[15:0]);
    rd(4'h4);
    chk("done", 16'h0001, d);
    // second message with more left, frame irq
    m(16'h0101, 16'hFFFD);
    m(16'h1003, 16'h0200);
    wr(4'h2, 16'h0001);
    ww(16'h0101);
    chk("count", 16'hFFFE, i_far.ram[13'h0101]);
    chk("irq", 16'h0002, irqs[15:0]);
    // area B, error with halt
    m(16'h0104, 16'h0000);
    m(16'h0105, 16'hFFFD);
    m(16'h0003, 16'h0300);
    m(16'h0300, 16'h0000);
    slow <= 1'b0;
    err_req <= 1'b1;
    wr(4'h0, 16'h000C);
    wr(4'h1, 16'h0001);
    wr(4'h2, 16'h0001);
    ww(16'h0105);
    chk("status", 16'h0006, i_far.ram[13'h0000]);
    chk("sp", 16'h0004, i_far.ram[13'h0104]);
    chk("count", 16'hFFFE, i_far.ram[13'h0105]);
    chk("irq", 16'h0003, irqs[15:0]);
    wr(4'h2, 16'h0001);
    repeat (40) @(posedge clock);
    chk("starts", 16'h0003, starts[15:0]);
    // terminal mode lookups, corner entries
    err_req <= 1'b0;
    wr(4'h0, 16'h0001);
    m(16'h0100, 16'h0040);
    for (int i = 0; i < 4; i++) begin
      k = {i[0], {5{i[1]}}};
      m(16'h0140 + k, 16'h0A00 + k);
      rt(k[5], k[4:0]);
      ww(16'h0100);
      chk("lut", 16'h0A00 + k, bp);
    end
    chk("sp", 16'h0050, i_far.ram[13'h0100]);
    summarize();
  end
endmodule // tb_bus1553_bc_rtu_msg_sequencer
bind bmsq_seq bmsq_seq_sva i_sva (.clock(clock), .sys_rst(sys_rst), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .tag_en_n(tag_en_n), .xfer_start(xfer_start),
  .xfer_done(xfer_done), .int_n(int_n));
